/* src/hap_map.svh */
`ifndef HAP_MAP_SVH
`define HAP_MAP_SVH
// Port offsets
`define HAP_OFS_CTRL_STAT 2'h0
`define HAP_OFS_DATA 2'h1
`define HAP_OFS_IRQ 2'h2
// Control bits
`define HAP_CTL_FULL_RST 7
`define HAP_CTL_LIGHT_RST 6
`define HAP_CTL_IRQ_CLR 5
`define HAP_CTL_BUS_RST 4
// Status bits
`define HAP_ST_SELFTEST 7
`define HAP_ST_DIAGFAIL 6
`define HAP_ST_MBINIT 5
`define HAP_ST_IDLE 4
`define HAP_ST_OUTFULL 3
`define HAP_ST_INFULL 2
`define HAP_ST_INVCMD 0
// Interrupt flag bits
`define HAP_IF_ANY 7
`define HAP_IF_BUSRST 3
`define HAP_IF_CMDDONE 2
`define HAP_IF_OUTBOX 1
`define HAP_IF_INBOX 0
// Reset values
`define HAP_IRQ_RESET 4'h0
`define HAP_BYTE_RESET 8'h00
// Data-in FIFO
`define HAP_FIFO_DEPTH 8
`define HAP_FIFO_AW 3
`endif

/* src/hap_pkg.sv */
package hap_pkg;
    typedef logic [7:0] hap_byte_t;
    typedef enum logic [1:0]
    {
        HAP_ST_BUSY = 2'h0,
        HAP_ST_INIT = 2'h1,
        HAP_ST_READY = 2'h3,
        HAP_ST_FAIL = 2'h2
    } hap_state_e;
endpackage : hap_pkg

/* src/hap_stream_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface hap_stream_if;
    logic [7:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport dst (input data, input valid, output ready);
endinterface : hap_stream_if
`default_nettype wire

/* src/hap_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module hap_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int AW = 3
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    hap_stream_if.dst in_s,
    hap_stream_if.src out_s
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    wire do_wr;
    wire do_rd;
    wire full;
    wire empty;
    assign empty = (wr_ptr == rd_ptr);
    assign full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && !empty;
    assign in_s.ready = !full;
    assign out_s.valid = !empty;
    assign out_s.data = mem[rd_ptr[AW-1:0]];
    assign do_wr = in_s.valid && !full;
    assign do_rd = out_s.ready && !empty;

    always_ff @(posedge clk)
    begin
        if (do_wr)
            mem[wr_ptr[AW-1:0]] <= in_s.data;
    end

    always_ff @(posedge clk)
    begin
        if (rst || flush)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (do_wr)
                wr_ptr <= wr_ptr + 1'b1;
            if (do_rd)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule : hap_fifo
`default_nettype wire

/* src/hap_irq.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hap_map.svh"
module hap_irq
(
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic in_full,
    input wire logic set_busrst,
    input wire logic set_cmddone,
    input wire logic set_outbox,
    input wire logic set_inbox,
    output logic [7:0] flags,
    output logic irq
);
    logic [3:0] cause;
    logic [3:0] pend;
    wire any;
    wire hi_present;
    wire can_hi;
    wire [3:0] req;
    wire [3:0] post;
    assign any = |cause;
    assign hi_present = cause[`HAP_IF_BUSRST] | cause[`HAP_IF_CMDDONE];
    // Reset/complete shown only with no cause flag set and data-in empty
    assign can_hi = !any && !in_full;
    // Mailbox causes wait behind reset/complete
    assign req = pend | {set_busrst, set_cmddone, set_outbox, set_inbox};
    assign post[3] = req[3] && can_hi;
    assign post[2] = req[2] && can_hi && !post[3];
    assign post[1] = req[1] && !hi_present;
    assign post[0] = req[0] && !hi_present;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cause <= `HAP_IRQ_RESET;
            pend <= `HAP_IRQ_RESET;
        end
        else
        begin
            // Clear drops old causes; new ones wait a cycle
            cause <= (clear ? 4'h0 : cause) | (clear ? 4'h0 : post);
            pend <= clear ? req : (req & ~post);
        end
    end

    assign flags = {any, 3'b000, cause};
    assign irq = any;
endmodule : hap_irq
`default_nettype wire

/* src/hap_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hap_map.svh"
module hap_port
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Host I/O side
    input wire logic [1:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic host_irq,
    // Reset requests to the rest of the adapter
    output logic full_reset_strobe,
    output logic light_reset_strobe,
    output logic bus_reset_req,
    // Adapter-side diagnostics
    input wire logic diag_done,
    input wire logic diag_ok,
    input wire logic mbox_init_done,
    input wire logic busy,
    // Adapter-side command path
    output logic out_valid,
    output hap_pkg::hap_byte_t out_byte,
    input wire logic out_take,
    input wire logic out_invalid,
    input wire logic cmd_end,
    input wire logic in_valid,
    input wire hap_pkg::hap_byte_t in_byte,
    output logic in_ready,
    // Other cause inputs
    input wire logic bus_reset_seen_cause,
    input wire logic outbox_slot_free_cause,
    input wire logic inbox_entry_cause
);
    import hap_pkg::*;

    // ========================================
    // Bus strobe registration
    logic wr_q;
    logic rd_q;
    logic [1:0] addr_q;
    hap_byte_t wdata_q;
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= 2'h0;
            wdata_q <= `HAP_BYTE_RESET;
        end
        else
        begin
            wr_q <= io_wr;
            rd_q <= io_rd;
            addr_q <= io_addr;
            wdata_q <= io_wdata;
        end
    end
    logic wr_d1;
    logic rd_d1;
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            wr_d1 <= 1'b0;
            rd_d1 <= 1'b0;
        end
        else
        begin
            wr_d1 <= wr_q;
            rd_d1 <= rd_q;
        end
    end
    // One access per strobe
    wire wr_ev = wr_q && !wr_d1;
    wire rd_ev = rd_q && !rd_d1;
    wire wr_ctrl = wr_ev && addr_q == `HAP_OFS_CTRL_STAT;
    wire wr_data = wr_ev && addr_q == `HAP_OFS_DATA;
    wire rd_data = rd_ev && addr_q == `HAP_OFS_DATA;

    // ========================================
    // Control port: self-clearing strobes
    wire hard_rst_w = wr_ctrl && wdata_q[`HAP_CTL_FULL_RST];
    wire soft_rst_w = wr_ctrl && wdata_q[`HAP_CTL_LIGHT_RST];
    wire irq_clr_w = wr_ctrl && wdata_q[`HAP_CTL_IRQ_CLR];
    wire bus_rst_w = wr_ctrl && wdata_q[`HAP_CTL_BUS_RST];
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            full_reset_strobe <= 1'b0;
            light_reset_strobe <= 1'b0;
            bus_reset_req <= 1'b0;
        end
        else
        begin
            full_reset_strobe <= hard_rst_w;
            light_reset_strobe <= soft_rst_w;
            bus_reset_req <= bus_rst_w;
        end
    end
    wire any_rst = sys_rst || hard_rst_w || soft_rst_w;

    // ========================================
    // Diagnostic state
    hap_state_e state;
    hap_state_e next_state;
    always_comb
    begin
        next_state = state;
        case (state)
            HAP_ST_BUSY:
                if (diag_done)
                    next_state = diag_ok ? HAP_ST_INIT : HAP_ST_FAIL;
            HAP_ST_INIT:
                if (mbox_init_done)
                    next_state = HAP_ST_READY;
            HAP_ST_READY:
                next_state = HAP_ST_READY;
            HAP_ST_FAIL:
                next_state = HAP_ST_FAIL;
            default:
                next_state = HAP_ST_BUSY;
        endcase
    end
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || hard_rst_w)
            state <= HAP_ST_BUSY;
        else if (soft_rst_w && state != HAP_ST_BUSY && state != HAP_ST_FAIL)
            state <= HAP_ST_INIT;
        else
            state <= next_state;
    end

    // ========================================
    // Out port
    hap_byte_t out_reg;
    logic out_full;
    always_ff @(posedge sys_clk)
    begin
        if (any_rst)
        begin
            out_full <= 1'b0;
            out_reg <= `HAP_BYTE_RESET;
        end
        else if (wr_data)
        begin
            out_full <= 1'b1;
            out_reg <= wdata_q;
        end
        else if (out_take)
            out_full <= 1'b0;
    end
    assign out_valid = out_full;
    assign out_byte = out_reg;

    // ========================================
    // Invalid flag and command tracking
    logic inv_flag;
    logic cmd_open;
    always_ff @(posedge sys_clk)
    begin
        if (any_rst)
            inv_flag <= 1'b0;
        else if (out_take && out_invalid)
            inv_flag <= 1'b1;
        else if (wr_data && !cmd_open)
            inv_flag <= 1'b0;
    end
    always_ff @(posedge sys_clk)
    begin
        if (any_rst)
            cmd_open <= 1'b0;
        else if (out_take && out_invalid)
            cmd_open <= 1'b0;
        else if (cmd_end)
            cmd_open <= 1'b0;
        else if (wr_data)
            cmd_open <= 1'b1;
    end
    // Idle already while waiting for mailbox setup
    wire diag_passed = state == HAP_ST_INIT || state == HAP_ST_READY;
    wire idle = !cmd_open && !out_full && !busy && diag_passed;

    // ========================================
    // Data-in path through FIFO
    hap_stream_if fin ();
    hap_stream_if fout ();
    assign fin.data = in_byte;
    assign fin.valid = in_valid;
    assign in_ready = fin.ready;
    hap_fifo #(
        .WIDTH(8),
        .DEPTH(`HAP_FIFO_DEPTH),
        .AW(`HAP_FIFO_AW)
    ) u_fifo (
        .clk(sys_clk),
        .rst(sys_rst),
        .flush(hard_rst_w || soft_rst_w),
        .in_s(fin),
        .out_s(fout)
    );
    hap_byte_t in_reg;
    logic in_full;
    assign fout.ready = !in_full || rd_data;
    always_ff @(posedge sys_clk)
    begin
        if (any_rst)
        begin
            in_full <= 1'b0;
            in_reg <= `HAP_BYTE_RESET;
        end
        else if (fout.valid && fout.ready)
        begin
            in_full <= 1'b1;
            in_reg <= fout.data;
        end
        else if (rd_data)
            in_full <= 1'b0;
    end

    // ========================================
    // Completion: after data drained, or at once if invalid
    logic done_pend;
    wire drained = !in_full && !fout.valid;
    wire done_fire = done_pend && (drained || inv_flag);
    always_ff @(posedge sys_clk)
    begin
        if (any_rst)
            done_pend <= 1'b0;
        else if (cmd_end || (out_take && out_invalid))
            done_pend <= 1'b1;
        else if (done_fire)
            done_pend <= 1'b0;
    end

    // ========================================
    // Interrupt flags
    logic [7:0] irq_flags;
    hap_irq u_irq (
        .clk(sys_clk),
        .rst(any_rst),
        .clear(irq_clr_w),
        .in_full(in_full),
        .set_busrst(bus_reset_seen_cause),
        .set_cmddone(done_fire),
        .set_outbox(outbox_slot_free_cause),
        .set_inbox(inbox_entry_cause),
        .flags(irq_flags),
        .irq(host_irq)
    );

    // ========================================
    // Read mux
    wire [7:0] status = {
        state == HAP_ST_BUSY,
        state == HAP_ST_FAIL,
        state == HAP_ST_INIT,
        idle,
        out_full,
        in_full,
        1'b0,
        inv_flag
    };
    wire [7:0] rd_mux = (io_addr == `HAP_OFS_CTRL_STAT) ? status :
                        (io_addr == `HAP_OFS_DATA) ? in_reg :
                        (io_addr == `HAP_OFS_IRQ) ? irq_flags : 8'h00;
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            io_rdata <= `HAP_BYTE_RESET;
        else
            io_rdata <= rd_mux;
    end
endmodule : hap_port
`default_nettype wire

/* test/hap_port_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port protocol checker
module hap_port_chk
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [1:0] io_addr,
    input wire logic io_wr,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic host_irq,
    input wire logic full_reset_strobe,
    input wire logic light_reset_strobe,
    input wire logic bus_reset_req,
    input wire logic out_valid,
    input wire logic out_take
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    // Rising write strobe at a given offset
    sequence s_wr(ofs);
        !io_wr ##1 io_wr && io_addr == ofs;
    endsequence
    property p_rst_quiet;
        $fell(sys_rst) |-> !host_irq && io_rdata == 8'h00;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("irq or read data set after reset");
    property p_rsv_irq;
        $past(io_addr) == 2'h2 |-> io_rdata[6:4] == 3'h0;
    endproperty
    a_rsv_irq: assert property (p_rsv_irq)
        else $error("flag bits 6..4 not zero");
    property p_rsv_st;
        $past(io_addr) == 2'h0 |-> !io_rdata[1];
    endproperty
    a_rsv_st: assert property (p_rsv_st)
        else $error("status bit 1 not zero");
    property p_any_or;
        $past(io_addr) == 2'h2 |-> io_rdata[7] == |io_rdata[3:0];
    endproperty
    a_any_or: assert property (p_any_or)
        else $error("any flag differs from causes");
    property p_irq_line;
        $past(io_addr) == 2'h2 |-> io_rdata[7] == $past(host_irq);
    endproperty
    a_irq_line: assert property (p_irq_line)
        else $error("irq line differs from any flag");
    property p_out_full;
        s_wr(2'h1) |-> ##[1:3] out_valid;
    endproperty
    a_out_full: assert property (p_out_full)
        else $error("out port not full after write");
    property p_take_clr;
        out_valid && out_take |=> !out_valid;
    endproperty
    a_take_clr: assert property (p_take_clr)
        else $error("out port still full after take");
    property p_hard_rst;
        s_wr(2'h0) ##1 io_wdata[7] |-> ##[0:2] full_reset_strobe;
    endproperty
    a_hard_rst: assert property (p_hard_rst)
        else $error("no full reset after control write");
    property p_irq_clr;
        s_wr(2'h0) ##1 io_wdata[5] |-> ##[1:4] !host_irq;
    endproperty
    a_irq_clr: assert property (p_irq_clr)
        else $error("irq line not cleared");
    property p_light_rst;
        s_wr(2'h0) ##1 io_wdata[6] |-> ##[0:2] light_reset_strobe;
    endproperty
    a_light_rst: assert property (p_light_rst)
        else $error("no light reset after control write");
    property p_bus_rst;
        s_wr(2'h0) ##1 io_wdata[4] |-> ##[0:2] bus_reset_req;
    endproperty
    a_bus_rst: assert property (p_bus_rst)
        else $error("no bus reset request after control write");
    property p_rst_irq;
        full_reset_strobe || light_reset_strobe |-> ##[0:2] !host_irq;
    endproperty
    a_rst_irq: assert property (p_rst_irq)
        else $error("irq line kept over reset");
endmodule : hap_port_chk
bind hap_port hap_port_chk u_chk (.sys_clk, .sys_rst, .io_addr, .io_wr,
    .io_wdata, .io_rdata, .host_irq, .full_reset_strobe,
    .light_reset_strobe, .bus_reset_req, .out_valid, .out_take);
`default_nettype wire

/* test/hap_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Host bus master model
module hap_host
(
    input wire logic sys_clk,
    output logic [1:0] io_addr,
    output logic io_rd,
    output logic io_wr,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata
);
    int gap = 1;
    initial
    begin
        io_addr = 2'h0;
        io_rd = 1'b0;
        io_wr = 1'b0;
        io_wdata = 8'h00;
    end
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        repeat (2) @(negedge sys_clk);
        io_wr = 1'b0;
        // Stale data once released
        io_wdata = ~d;
        repeat (gap) @(negedge sys_clk);
    endtask : wr
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge sys_clk);
        d = io_rdata;
        @(negedge sys_clk);
        io_rd = 1'b0;
        repeat (gap) @(negedge sys_clk);
    endtask : rd
endmodule : hap_host
`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
        num_errors++; \
        $display("[FAIL] %s exp %h got %h", nm, e, g); \
    end
`define PULSE(s) \
    @(negedge sys_clk); \
    s = 1'b1; \
    @(negedge sys_clk); \
    s = 1'b0;
module testbench;
    import hap_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    int num_errors = 0;
    int tests_run = 0;
    logic [1:0] io_addr;
    logic io_rd, io_wr, host_irq, out_valid, in_ready;
    logic [7:0] io_wdata, io_rdata;
    hap_byte_t out_byte;
    hap_byte_t in_byte = 8'h00;
    logic diag_done = 1'b0, diag_ok = 1'b0, mbox_init_done = 1'b0;
    logic busy = 1'b0, out_take = 1'b0, out_invalid = 1'b0;
    logic cmd_end = 1'b0, in_valid = 1'b0, bus_reset_seen_cause = 1'b0;
    logic outbox_slot_free_cause = 1'b0, inbox_entry_cause = 1'b0;
    int n;
    always #10 sys_clk = ~sys_clk;
    hap_host host (.sys_clk, .io_addr, .io_rd, .io_wr, .io_wdata,
        .io_rdata);
    hap_port dut (.sys_clk, .sys_rst, .io_addr, .io_rd, .io_wr,
        .io_wdata, .io_rdata, .host_irq, .full_reset_strobe(),
        .light_reset_strobe(), .bus_reset_req(), .diag_done, .diag_ok,
        .mbox_init_done, .busy, .out_valid, .out_byte, .out_take,
        .out_invalid, .cmd_end, .in_valid, .in_byte, .in_ready,
        .bus_reset_seen_cause, .outbox_slot_free_cause,
        .inbox_entry_cause);
    // ==========
    // Helpers
    task automatic look(input logic [1:0] a, input logic [7:0] m,
        input logic [7:0] e, input string s);
        logic [7:0] v;
        repeat (4) @(negedge sys_clk);
        host.rd(a, v);
        `CHK(s, e, v & m)
    endtask : look
    task complete_run;
        if (num_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    // ==========
    // Scenarios
    task automatic t_reset;
        look(2'h0, 8'hFF, 8'h80, "status");
        look(2'h2, 8'hFF, 8'h00, "flags");
        look(2'h3, 8'hFF, 8'h00, "unused");
    endtask : t_reset
    task automatic t_diag;
        `PULSE(diag_done)
        look(2'h0, 8'hE0, 8'h40, "fail");
        look(2'h0, 8'hE0, 8'h40, "fail held");
        host.wr(2'h0, 8'h80);
        look(2'h0, 8'hC0, 8'h80, "hard");
        diag_ok = 1'b1;
        `PULSE(diag_done)
        look(2'h0, 8'hF0, 8'h30, "ready");
        busy = 1'b1;
        look(2'h0, 8'h10, 8'h00, "busy");
        busy = 1'b0;
        `PULSE(mbox_init_done)
    endtask : t_diag
    task automatic t_out;
        host.wr(2'h1, 8'hA5);
        look(2'h0, 8'h08, 8'h08, "out full");
        `CHK("out byte", 8'hA5, out_byte)
        `PULSE(out_take)
        look(2'h0, 8'h08, 8'h00, "out taken");
    endtask : t_out
    task automatic t_in;
        n = 0;
        in_valid = 1'b1;
        while (in_ready === 1'b1 && n < 20)
        begin
            in_byte = 8'h10 + n[7:0];
            @(negedge sys_clk);
            n++;
        end
        in_valid = 1'b0;
        `CHK("fifo depth", 1'b1, n >= 8)
        `PULSE(cmd_end)
        look(2'h2, 8'hFF, 8'h00, "early");
        for (int i = 0; i < n; i++)
        begin
            look(2'h0, 8'h04, 8'h04, "in full");
            look(2'h1, 8'hFF, 8'h10 + i[7:0], "in byte");
        end
        look(2'h0, 8'h05, 8'h00, "in empty");
        look(2'h2, 8'hFF, 8'h84, "done");
        `CHK("line", 1'b1, host_irq)
    endtask : t_in
    task automatic t_irq;
        host.gap = 3;
        host.wr(2'h0, 8'h20);
        look(2'h2, 8'hFF, 8'h00, "cleared");
        host.wr(2'h1, 8'h99);
        out_invalid = 1'b1;
        `PULSE(out_take)
        out_invalid = 1'b0;
        look(2'h0, 8'h09, 8'h01, "invalid");
        look(2'h2, 8'hFF, 8'h84, "abort");
        `PULSE(inbox_entry_cause)
        `PULSE(outbox_slot_free_cause)
        look(2'h2, 8'hFF, 8'h84, "deferred");
        host.wr(2'h0, 8'h20);
        look(2'h2, 8'hFF, 8'h83, "posted");
        host.wr(2'h0, 8'h20);
        `PULSE(bus_reset_seen_cause)
        look(2'h2, 8'hFF, 8'h88, "bus reset");
        host.wr(2'h0, 8'h40);
        look(2'h2, 8'hFF, 8'h00, "light");
        `CHK("line off", 1'b0, host_irq)
        in_byte = 8'h5A;
        `PULSE(in_valid)
        `PULSE(bus_reset_seen_cause)
        look(2'h2, 8'hFF, 8'h00, "held by data");
        look(2'h1, 8'hFF, 8'h5A, "held byte");
        look(2'h2, 8'hFF, 8'h88, "shown");
        host.wr(2'h0, 8'h10);
        `CHK("line kept", 1'b1, host_irq)
    endtask : t_irq
    initial
    begin
        repeat (5) @(negedge sys_clk);
        sys_rst = 1'b0;
        @(negedge sys_clk);
        t_reset();
        t_diag();
        t_out();
        t_in();
        t_irq();
        complete_run();
    end
    initial
    begin
        repeat (8000) @(posedge sys_clk);
        num_errors++;
        complete_run();
    end
endmodule : testbench
`default_nettype wire
